// ==== pcr_consts.svh ====
/*
  offsets, field positions, reset values of the processor control registers.
  assumes inclusion by bare name from the design module and the testbench.
*/
`ifndef PCR_CONSTS_SVH
`define PCR_CONSTS_SVH
`define PCR_OFF_AUX_CONFIG      8'hf2
`define PCR_OFF_RELEASE_LEVEL   8'hf4
`define PCR_OFF_RESET_CONFIG    8'hf6
`define PCR_OFF_RELOCATION      8'hfe
`define PCR_RELOC_RESET         16'h20ff
`define PCR_AUX_RESET           16'h0000
`define PCR_AUX_MASK            16'h007f
`define PCR_RELOC_MASK          16'h5fff
`define PCR_BIT_SLAVE           14
`define PCR_BIT_MEM_SPACE       12
`define PCR_BIT_P1_RX_EN        6
`define PCR_BIT_P1_SEND         5
`define PCR_BIT_P0_RX_EN        4
`define PCR_BIT_P0_SEND         3
`define PCR_BIT_LOW_WIDTH       2
`define PCR_BIT_MID_WIDTH       1
`define PCR_BIT_IO_WIDTH        0
`define PCR_RELEASE_CODE        8'h5a
`define PCR_BASE_SHIFT          8
`endif

// ==== pcr_pkg.sv ====
/*
  types shared by the processor control register bank.
  assumes pcr_consts.svh is on the include path.
*/
package pcr_pkg;
  typedef logic [15:0] pcr_word_t;
  typedef logic [19:0] pcr_addr_t;
endpackage : pcr_pkg

// ==== pcr_regs.sv ====
/*
  processor control register bank of the relocatable peripheral register block:
  the block relocation register, the reset configuration capture, the release
  level word and the auxiliary configuration register.
  assumes a single-cycle internal bus from the core: i_rd/i_wr strobes with a
  20-bit address and a memory/io space flag; read data is registered.
  assumes the strobes last one cycle each, with no wait states; a read and a
  write in the same cycle both take effect.
  assumes no byte lanes: every access moves a whole 16-bit word.
  assumes misses produce no answer and leave every register alone.
  assumes i_muxed_addr_data carries the pin levels, already synchronous, and
  that the board supplies them while i_nrst is low.
  assumes software keeps the top four base bits zero when mapping into io space.
  the release code is a parameter whose default is an arbitrary value.
  the bus pins are only ever sampled here; the output enable stays high.
*/
// What this block does
// - relocation supplies upper twelve base bits
// - base low eight bits are zero
// - serve accesses within 256-byte block
// - bit 12 selects memory or io
// - io mapping ignores top four bits
// - bit 14 selects interrupt slave mode
// - relocation resets to 20ff
// - capture bus levels while reset low
// - bus undriven during reset
// - bus line n maps to bit n
// - captured value read-only until reset
// - release level fixed code, low reserved
// - aux resets zero, bits 15-7 reserved
// - bits 6/4 choose receiver-enable function
// - bits 5/3 choose send-request alternate
// - bit 2 low space width
// - bit 1 midrange memory width
// - bit 0 io space width
`timescale 1ns/1ns
`include "pcr_consts.svh"
module pcr_regs
  import pcr_pkg::*;
#(
  parameter logic [7:0] RELEASE_CODE = `PCR_RELEASE_CODE  // arbitrary value
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_rd,
  input  wire logic        i_wr,
  input  wire logic        i_mem_space,
  input  wire logic [19:0] i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic [15:0] i_muxed_addr_data,
  output logic      [15:0] o_rdata,
  output logic             o_block_hit,
  output logic             o_muxed_addr_data_oe_n,
  output logic             o_irq_slave_mode,
  output logic             o_block_in_mem,
  output logic [19:0]      o_block_base,
  output logic             o_port1_rx_enable_request,
  output logic             o_port1_send_request,
  output logic             o_port0_rx_enable_request,
  output logic             o_port0_send_request,
  output logic             o_low_space_width,
  output logic             o_middle_space_width,
  output logic             o_io_space_width
);

  // reserved relocation bits 15 and 13 and aux bits 15..7 never take write data; a write clears them
  localparam pcr_word_t RELOC_KEEP  = `PCR_RELOC_MASK;
  localparam pcr_word_t AUX_KEEP    = `PCR_AUX_MASK;
  localparam pcr_word_t RELOC_RESET = `PCR_RELOC_RESET;
  localparam pcr_word_t AUX_RESET   = `PCR_AUX_RESET;
  localparam int        AUX_BITS    = 7;

  // registers and their next values
  pcr_word_t           block_relocation_reg;
  pcr_word_t           block_relocation_next;
  pcr_word_t           aux_config_reg;
  pcr_word_t           aux_config_next;
  pcr_word_t           reset_config_latch_reg;
  pcr_word_t           reset_config_latch_next;
  pcr_word_t           rdata_reg;
  pcr_word_t           rdata_next;

  // decode and strobe signals
  pcr_word_t           release_word;
  pcr_addr_t           base;
  logic [11:0]         reloc_field;
  logic [11:0]         addr_page_mem;
  logic [11:0]         base_page_mem;
  logic [7:0]          addr_page_io;
  logic [7:0]          base_page_io;
  logic [7:0]          offset;
  logic                in_mem;
  logic                slave_mode;
  logic                space_ok;
  logic                mem_page_ok;
  logic                io_page_ok;
  logic                page_ok;
  logic                hit;
  logic                sel_reloc;
  logic                sel_aux;
  logic                sel_release;
  logic                sel_reset_cfg;
  logic [1:0]          strobe_pair;
  logic                wr_reloc;
  logic                wr_aux;
  logic                rd_hit;
  logic [AUX_BITS-1:0] aux_bits;

  // relocation fields
  assign reloc_field = block_relocation_reg[11:0];
  assign in_mem      = block_relocation_reg[`PCR_BIT_MEM_SPACE];
  assign slave_mode  = block_relocation_reg[`PCR_BIT_SLAVE];
  assign base        = {reloc_field, 8'h00};

  // address slices used by the block match
  assign offset        = i_addr[7:0];
  assign addr_page_mem = i_addr[19:8];
  assign addr_page_io  = i_addr[15:8];
  assign base_page_mem = base[19:8];
  assign base_page_io  = base[15:8];

  // the access must be in the space the block lives in
  always_comb begin
    space_ok = 1'b0;
    if (in_mem) begin
      space_ok = i_mem_space;
    end else begin
      space_ok = !i_mem_space;
    end
  end

  // both page matches; io addresses are 16 bits wide, so the top base bits take no part
  assign mem_page_ok = (addr_page_mem == base_page_mem);
  assign io_page_ok  = (addr_page_io == base_page_io);

  always_comb begin
    page_ok = 1'b0;
    if (in_mem) begin
      page_ok = mem_page_ok;
    end else begin
      page_ok = io_page_ok;
    end
  end

  // a hit needs both the space and the page
  assign hit = space_ok && page_ok;

  // offset decode inside the 256-byte block
  always_comb begin
    sel_reloc     = 1'b0;
    sel_aux       = 1'b0;
    sel_release   = 1'b0;
    sel_reset_cfg = 1'b0;
    if (hit) begin
      case (offset)
        `PCR_OFF_RELOCATION: begin
          sel_reloc = 1'b1;
        end
        `PCR_OFF_AUX_CONFIG: begin
          sel_aux = 1'b1;
        end
        `PCR_OFF_RELEASE_LEVEL: begin
          sel_release = 1'b1;
        end
        `PCR_OFF_RESET_CONFIG: begin
          sel_reset_cfg = 1'b1;
        end
        default: begin
          sel_reloc = 1'b0;
        end
      endcase
    end
  end

  // a read and a write in the same cycle both act
  assign strobe_pair = {i_wr, i_rd};

  always_comb begin
    rd_hit   = 1'b0;
    wr_reloc = 1'b0;
    wr_aux   = 1'b0;
    case (strobe_pair)
      2'b00: begin
        rd_hit = 1'b0;
      end
      2'b01: begin
        rd_hit = hit;
      end
      2'b10: begin
        wr_reloc = sel_reloc;
        wr_aux   = sel_aux;
      end
      2'b11: begin
        rd_hit   = hit;
        wr_reloc = sel_reloc;
        wr_aux   = sel_aux;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // relocation next value: live bits take the write, reserved bits clear
  for (genvar g = 0; g < 16; g++) begin : g_reloc_bit
    logic next_bit;
    always_comb begin
      next_bit = block_relocation_reg[g];
      if (wr_reloc) begin
        if (RELOC_KEEP[g]) begin
          next_bit = i_wdata[g];
        end else begin
          next_bit = 1'b0;
        end
      end
    end
    assign block_relocation_next[g] = next_bit;
  end

  // reset puts the block back in io space at its default page
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      block_relocation_reg <= RELOC_RESET;
    end else begin
      block_relocation_reg <= block_relocation_next;
    end
  end

  // aux next value: only bits 6..0 are kept
  for (genvar g = 0; g < 16; g++) begin : g_aux_bit_next
    logic next_bit;
    always_comb begin
      next_bit = aux_config_reg[g];
      if (wr_aux) begin
        if (AUX_KEEP[g]) begin
          next_bit = i_wdata[g];
        end else begin
          next_bit = 1'b0;
        end
      end
    end
    assign aux_config_next[g] = next_bit;
  end

  // every pin function and bus width falls back to its plain setting on reset
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      aux_config_reg <= AUX_RESET;
    end else begin
      aux_config_reg <= aux_config_next;
    end
  end

  // capture follows the bus pins on every edge while reset is low; writes never reach it
  for (genvar g = 0; g < 16; g++) begin : g_capture_bit
    logic next_bit;
    always_comb begin
      if (!i_nrst) begin
        next_bit = i_muxed_addr_data[g];
      end else begin
        next_bit = reset_config_latch_reg[g];
      end
    end
    assign reset_config_latch_next[g] = next_bit;
  end

  // no reset branch: reset is exactly what feeds the capture
  always_ff @(posedge i_ref_clk) begin
    reset_config_latch_reg <= reset_config_latch_next;
  end

  // fixed code in the high byte, reserved low byte
  assign release_word = {RELEASE_CODE, 8'h00};

  // read data stands one cycle after a hitting read and is zero otherwise
  always_comb begin
    rdata_next = 16'h0000;
    if (rd_hit) begin
      if (sel_reloc) begin
        rdata_next = block_relocation_reg;
      end else if (sel_aux) begin
        rdata_next = aux_config_reg;
      end else if (sel_reset_cfg) begin
        rdata_next = reset_config_latch_reg;
      end else if (sel_release) begin
        rdata_next = release_word;
      end else begin
        rdata_next = 16'h0000;
      end
    end
  end

  // read data is cleared while reset is low
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      rdata_reg <= 16'h0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // one output pin per live aux bit
  for (genvar g = 0; g < AUX_BITS; g++) begin : g_aux_bit
    assign aux_bits[g] = aux_config_reg[g];
  end

  // relocation controls seen by the rest of the device
  always_comb begin
    o_block_base     = base;
    o_block_in_mem   = in_mem;
    o_irq_slave_mode = slave_mode;
    o_block_hit      = hit;
  end

  // flow-control pin functions of both serial ports
  always_comb begin
    o_port1_rx_enable_request = aux_bits[`PCR_BIT_P1_RX_EN];
    o_port0_rx_enable_request = aux_bits[`PCR_BIT_P0_RX_EN];
    o_port1_send_request      = aux_bits[`PCR_BIT_P1_SEND];
    o_port0_send_request      = aux_bits[`PCR_BIT_P0_SEND];
  end

  // 8-bit (one) or 16-bit (zero) bus width per address space
  always_comb begin
    o_low_space_width    = aux_bits[`PCR_BIT_LOW_WIDTH];
    o_middle_space_width = aux_bits[`PCR_BIT_MID_WIDTH];
    o_io_space_width     = aux_bits[`PCR_BIT_IO_WIDTH];
  end

  // read path and the bus pins, which this block never drives
  always_comb begin
    o_rdata                = rdata_reg;
    o_muxed_addr_data_oe_n = 1'b1;
  end

endmodule : pcr_regs

// ==== pcr_regs_chk_assertions.sv ====
/* port checker for pcr_regs
   assumes one clock and a sync active-low reset */
`timescale 1ns/1ns
module pcr_regs_chk (
  input wire logic        i_ref_clk, i_nrst, i_rd, i_wr, i_mem_space, o_block_hit,
  input wire logic        o_muxed_addr_data_oe_n, o_irq_slave_mode, o_block_in_mem,
  input wire logic        o_io_space_width,
  input wire logic [19:0] i_addr, o_block_base,
  input wire logic [15:0] i_wdata, o_rdata
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  wire rh = i_rd && o_block_hit;
  wire wh = i_wr && o_block_hit;
  a_bus_undriven: assert property (disable iff (1'b0) o_muxed_addr_data_oe_n)
    else $error("oe");
  a_base_low: assert property (o_block_base[7:0] == 8'h00) else $error("base");
  a_reset_vals: assert property ($rose(i_nrst) |-> o_block_base == 20'h0_ff00
    && !o_block_in_mem && !o_irq_slave_mode && !o_io_space_width) else $error("rst");
  a_reloc_write: assert property (wh && i_addr[7:0] == 8'hfe |=>
    o_block_base[19:8] == $past(i_wdata[11:0]) && o_block_in_mem == $past(i_wdata[12])
    && o_irq_slave_mode == $past(i_wdata[14])) else $error("wr");
  a_hit_decode: assert property (o_block_hit == (i_mem_space == o_block_in_mem
    && (o_block_in_mem ? i_addr[19:8] == o_block_base[19:8]
    : i_addr[15:8] == o_block_base[15:8]))) else $error("hit");
  a_rdata_idle: assert property (!rh |=> o_rdata == 16'h0000) else $error("rd");
  a_release_low: assert property (rh && i_addr[7:0] == 8'hf4 |=> o_rdata[7:0] == 8'h00)
    else $error("rl");
  a_aux_stable: assert property (!(wh && i_addr[7:0] == 8'hf2) |=>
    $stable(o_io_space_width)) else $error("aux");
  c_io_hit: cover property (rh && !o_block_in_mem);
  c_mem_hit: cover property (rh && o_block_in_mem);
  c_reloc: cover property (wh && i_addr[7:0] == 8'hfe);
endmodule : pcr_regs_chk
bind pcr_regs pcr_regs_chk i_pcr_regs_chk (.*);

// ==== pcr_core_model.sv ====
/* core-side master: one-cycle strobes, read data next cycle
   assumes pcr_regs bus contract */
`timescale 1ns/1ns
module pcr_core_model (
  input  wire logic        i_ref_clk,
  input  wire logic [15:0] i_rdata,
  output logic             o_rd, o_wr, o_mem,
  output logic [19:0]      o_addr,
  output logic [15:0]      o_wdata
);
  initial {o_rd, o_wr, o_mem, o_addr, o_wdata} = '0;
  // only the register block answers here, so no overlapping select exists
  task automatic acc(input logic w, m, input logic [19:0] a, input logic [15:0] d,
                     output logic [15:0] q);
    @(posedge i_ref_clk) #1 {o_wr, o_rd, o_mem, o_addr, o_wdata} = {w, !w, m, a, d};
    @(posedge i_ref_clk) #1 {o_wr, o_rd, o_addr, o_wdata} = {2'b00, ~a, ~d};
    q = i_rdata;
  endtask : acc
endmodule : pcr_core_model

// ==== processor_control_regs_tb_top.sv ====
/* self-checking bench for pcr_regs
   assumes pcr_consts.svh on the include path */
`timescale 1ns/1ns
`include "pcr_consts.svh"
module processor_control_regs_tb_top;
  import pcr_pkg::*;
  logic      i_ref_clk = 0, i_nrst = 0, i_rd, i_wr, i_mem_space, o_block_hit;
  logic      o_muxed_addr_data_oe_n, o_irq_slave_mode, o_block_in_mem, o_io_space_width;
  logic      o_port1_rx_enable_request, o_port1_send_request, o_port0_rx_enable_request;
  logic      o_port0_send_request, o_low_space_width, o_middle_space_width;
  pcr_addr_t i_addr, o_block_base;
  pcr_word_t i_wdata, o_rdata, i_muxed_addr_data, cfg, d, q, m_rel = 16'h20ff, m_aux = 0;
  integer    seed = 32'h5f4c, err_count = 0, n_compared = 0, r, k;
  logic [7:0] offs [5] = '{8'hf2, 8'hf4, 8'hf6, 8'hfe, 8'h00};
  pcr_regs i_pcr_regs (.*);
  pcr_core_model i_pcr_core_model (.i_ref_clk, .i_rdata(o_rdata), .o_rd(i_rd),
    .o_wr(i_wr), .o_mem(i_mem_space), .o_addr(i_addr), .o_wdata(i_wdata));
  task automatic chk(input logic [15:0] s, x);
    n_compared++;
    if (s !== x) begin
      err_count++;
      $display("BAD %0t seen %h exp %h", $time, s, x);
    end
  endtask : chk
  task automatic give_verdict;
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  function automatic pcr_addr_t at(input logic [7:0] o);
    return m_rel[12] ? {m_rel[11:0], o} : {4'h0, m_rel[7:0], o};
  endfunction : at
  function automatic pcr_word_t ex(input logic [7:0] o);
    case (o)
      8'hf2: return m_aux;
      8'hf4: return {`PCR_RELEASE_CODE, 8'h00};
      8'hf6: return cfg;
      8'hfe: return m_rel;
      default: return 16'h0000;
    endcase
  endfunction : ex
  initial forever #2 i_ref_clk = ~i_ref_clk;
  initial begin
    #20000 err_count++;
    give_verdict();
  end
  initial begin
    repeat (6) begin
      i_muxed_addr_data = 16'($random(seed));
      cfg = i_muxed_addr_data;
      @(posedge i_ref_clk) #1;
    end
    i_nrst = 1;
    i_muxed_addr_data = ~cfg;
    for (r = 0; r < 8; r++) begin
      for (k = 0; k < 5; k++) begin
        i_pcr_core_model.acc(0, m_rel[12], at(offs[k]), 16'h0000, q);
        chk(q, ex(offs[k]));
      end
      chk({9'h0, o_port1_rx_enable_request, o_port1_send_request, o_port0_rx_enable_request,
        o_port0_send_request, o_low_space_width, o_middle_space_width, o_io_space_width},
        m_aux);
      chk({o_irq_slave_mode, o_block_in_mem, o_block_base[19:6]},
        {m_rel[14], m_rel[12], m_rel[11:0], 2'b00});
      for (k = 0; k < 5; k++) begin
        d = 16'($random(seed));
        if (!d[12]) d[11:8] = 4'h0;
        i_pcr_core_model.acc(1, !m_rel[12], at(8'hfe), ~d, q);
        i_pcr_core_model.acc(1, m_rel[12], at(offs[k]), d, q);
        if (offs[k] == 8'hf2) m_aux = d & `PCR_AUX_MASK;
        if (offs[k] == 8'hfe) m_rel = d & `PCR_RELOC_MASK;
      end
    end
    give_verdict();
  end
endmodule : processor_control_regs_tb_top
